// *** hdl/atmop_port.sv ***
// How it works
// - transmit start-of-cell high exactly while first cell octet is on the bus.
// - receive enable low at receive clock rise yields one valid received octet.
// - octet after a rise with receive enable high is discarded.
// - transmit bus sampled at transmit clock rise, valid only with enable low.
// - disabled port releases every line to general-purpose use; enabled port leaves status lines undriven.
// - each transmit rise with enable low writes one octet into the framer.
`timescale 1ns/10ps
`default_nettype none
module atmop_port (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  // mode
  input  wire logic                   port_en_i,
  // link clocks from the framer
  input  wire logic                   tx_fifo_clock_i,
  input  wire logic                   rx_fifo_clock_i,
  // shared port lines
  input  wire atmop_pkg::atmop_pins_t pa_i,
  output var  atmop_pkg::atmop_pins_t pa_o,
  output var  atmop_pkg::atmop_pins_t pa_oe_o,
  // general-purpose use of the lines
  input  wire atmop_pkg::atmop_pins_t gpio_out_i,
  input  wire atmop_pkg::atmop_pins_t gpio_oe_i,
  output var  atmop_pkg::atmop_pins_t gpio_in_o,
  // transmit user side
  input  wire logic                   tx_valid_i,
  input  wire atmop_pkg::atmop_octet_t tx_octet_i,
  output logic                        tx_ready_o,
  // receive user side
  output logic                        rx_valid_o,
  output var  atmop_pkg::atmop_octet_t rx_octet_o
);

  // ==========================================================================
  // synchronisers; the link clocks are only sampled, never used as clocks
  atmop_pkg::atmop_pins_t pa_m_q, pa_s_q;
  logic tclk_m_q, tclk_s_q, tclk_p_q;
  logic rclk_m_q, rclk_s_q, rclk_p_q;
  logic tx_rise, rx_rise, rx_fall;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pa_m_q   <= atmop_pkg::ATMOP_PINS_ZERO;
      pa_s_q   <= atmop_pkg::ATMOP_PINS_ZERO;
      tclk_m_q <= 1'b0;
      tclk_s_q <= 1'b0;
      tclk_p_q <= 1'b0;
      rclk_m_q <= 1'b0;
      rclk_s_q <= 1'b0;
      rclk_p_q <= 1'b0;
    end else begin
      pa_m_q   <= pa_i;
      pa_s_q   <= pa_m_q;
      tclk_m_q <= tx_fifo_clock_i;
      tclk_s_q <= tclk_m_q;
      tclk_p_q <= tclk_s_q;
      rclk_m_q <= rx_fifo_clock_i;
      rclk_s_q <= rclk_m_q;
      rclk_p_q <= rclk_s_q;
    end
  end

  assign tx_rise   = tclk_s_q & ~tclk_p_q;
  assign rx_rise   = rclk_s_q & ~rclk_p_q;
  assign rx_fall   = ~rclk_s_q & rclk_p_q;
  assign gpio_in_o = pa_s_q;

  // ==========================================================================
  // transmit: outputs move a few cycles after a detected rise, so they are
  // stable across the framer's next sampling edge
  atmop_pkg::atmop_tx_st_t tx_st_q;
  logic [5:0] tx_sent_q;
  logic [7:0] txd_q;
  logic       txen_n_q;
  logic       tsoc_q;
  logic       tx_take;
  logic       tx_drop;

  // idle octets without a start mark cannot open a cell and are thrown away
  assign tx_drop = (tx_st_q == atmop_pkg::ATMOP_TX_IDLE) && !tx_octet_i.sof;
  assign tx_take = port_en_i && tx_rise && tx_valid_i &&
                   (tx_st_q == atmop_pkg::ATMOP_TX_IDLE ? (pa_s_q.tca && tx_octet_i.sof)
                                                        : (tx_sent_q != atmop_pkg::ATMOP_CELL_LEN));
  assign tx_ready_o = tx_take || (port_en_i && tx_rise && tx_valid_i && tx_drop);

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !port_en_i) begin
      tx_st_q   <= atmop_pkg::ATMOP_TX_IDLE;
      tx_sent_q <= atmop_pkg::ATMOP_CNT_ZERO;
      txd_q     <= 8'h00;
      txen_n_q  <= 1'b1;
      tsoc_q    <= 1'b0;
    end else if (tx_rise) begin
      unique case (tx_st_q)
        atmop_pkg::ATMOP_TX_IDLE: begin
          tsoc_q <= tx_take;
          txen_n_q <= !tx_take;
          if (tx_take) begin
            txd_q     <= tx_octet_i.data;
            tx_sent_q <= atmop_pkg::ATMOP_CNT_ONE;
            tx_st_q   <= atmop_pkg::ATMOP_TX_SEND;
          end
        end
        atmop_pkg::ATMOP_TX_SEND: begin
          tsoc_q   <= 1'b0;
          txen_n_q <= !tx_take;
          if (tx_take) begin
            txd_q     <= tx_octet_i.data;
            tx_sent_q <= tx_sent_q + atmop_pkg::ATMOP_CNT_ONE;
          end else if (tx_sent_q == atmop_pkg::ATMOP_CELL_LEN) begin
            tx_st_q <= atmop_pkg::ATMOP_TX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // receive: enable moves on falls, data is taken on falls, mid-octet
  atmop_pkg::atmop_rx_st_t rx_st_q;
  logic [5:0] rx_cnt_q;
  logic       rxen_n_q;
  logic       en_edge_q;
  logic       rx_valid_q;
  atmop_pkg::atmop_octet_t rx_octet_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !port_en_i) begin
      en_edge_q <= 1'b0;
      rx_cnt_q  <= atmop_pkg::ATMOP_CNT_ZERO;
    end else if (rx_rise) begin
      en_edge_q <= !rxen_n_q;
      if (!rxen_n_q) begin
        rx_cnt_q <= rx_cnt_q + atmop_pkg::ATMOP_CNT_ONE;
      end
    end else if (rx_fall && rx_st_q == atmop_pkg::ATMOP_RX_IDLE) begin
      rx_cnt_q <= atmop_pkg::ATMOP_CNT_ZERO;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !port_en_i) begin
      rx_st_q  <= atmop_pkg::ATMOP_RX_IDLE;
      rxen_n_q <= 1'b1;
    end else if (rx_fall) begin
      unique case (rx_st_q)
        atmop_pkg::ATMOP_RX_IDLE: begin
          if (pa_s_q.rca) begin
            rxen_n_q <= 1'b0;
            rx_st_q  <= atmop_pkg::ATMOP_RX_RECV;
          end
        end
        atmop_pkg::ATMOP_RX_RECV: begin
          if (rx_cnt_q == atmop_pkg::ATMOP_CELL_LEN) begin
            rxen_n_q <= 1'b1;
            rx_st_q  <= atmop_pkg::ATMOP_RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_valid_q <= 1'b0;
      rx_octet_q <= atmop_pkg::ATMOP_OCTET_ZERO;
    end else begin
      rx_valid_q <= port_en_i && rx_fall && en_edge_q;
      if (port_en_i && rx_fall && en_edge_q) begin
        rx_octet_q <= '{sof: pa_s_q.rsoc, data: pa_s_q.rxd};
      end
    end
  end

  assign rx_valid_o = rx_valid_q;
  assign rx_octet_o = rx_octet_q;

  // ==========================================================================
  // line ownership
  atmop_pkg::atmop_pins_t dev_out;

  always_comb begin
    dev_out      = atmop_pkg::ATMOP_PINS_ZERO;
    dev_out.txd  = txd_q;
    dev_out.txen = txen_n_q;
    dev_out.tsoc = tsoc_q;
    dev_out.rxen = rxen_n_q;
  end

  assign pa_o    = port_en_i ? dev_out : gpio_out_i;
  assign pa_oe_o = port_en_i ? atmop_pkg::ATMOP_DEV_OE : gpio_oe_i;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i || !port_en_i);

  sequence s_rx_enabled_edge;
    rx_rise && !rxen_n_q;
  endsequence

  sequence s_tx_open;
    tx_take && (tx_st_q == atmop_pkg::ATMOP_TX_IDLE);
  endsequence

  sequence s_tx_first_out;
    tsoc_q && !txen_n_q && (tx_sent_q == atmop_pkg::ATMOP_CNT_ONE);
  endsequence

  property p_tx_sof_first;
    s_tx_open |=> s_tx_first_out;
  endproperty
  a_tx_sof_first: assert property (p_tx_sof_first) else $error("start mark not on first octet");

  // the start mark stands until the next detected rise and then drops
  property p_tx_sof_span;
    tsoc_q |=> (tsoc_q == !$past(tx_rise));
  endproperty
  a_tx_sof_span: assert property (p_tx_sof_span) else $error("start mark span wrong");

  property p_tx_sof_alone;
    tsoc_q |-> !txen_n_q && (tx_sent_q == atmop_pkg::ATMOP_CNT_ONE);
  endproperty
  a_tx_sof_alone: assert property (p_tx_sof_alone) else $error("start mark without first octet");

  property p_tx_avail_first;
    $rose(tsoc_q) |-> $past(pa_s_q.tca);
  endproperty
  a_tx_avail_first: assert property (p_tx_avail_first) else $error("cell opened without avail");

  property p_tx_hold;
    (!txen_n_q && !tx_rise) |=> $stable(txd_q) && $stable(txen_n_q);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit octet moved between rises");

  property p_tx_cell_len;
    (tx_st_q == atmop_pkg::ATMOP_TX_SEND && tx_rise && tx_sent_q == atmop_pkg::ATMOP_CELL_LEN)
      |=> txen_n_q && (tx_st_q == atmop_pkg::ATMOP_TX_IDLE);
  endproperty
  a_tx_cell_len: assert property (p_tx_cell_len) else $error("cell longer than its length");

  property p_rx_capture;
    s_rx_enabled_edge |-> ##[1:40] rx_valid_q;
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("enabled receive edge lost");

  property p_rx_discard;
    (rx_fall && !en_edge_q) |=> !rx_valid_q;
  endproperty
  a_rx_discard: assert property (p_rx_discard) else $error("invalid receive octet kept");

  property p_rx_avail_first;
    $fell(rxen_n_q) |-> $past(pa_s_q.rca) && $past(rx_fall) && (rx_cnt_q == atmop_pkg::ATMOP_CNT_ZERO);
  endproperty
  a_rx_avail_first: assert property (p_rx_avail_first) else $error("receive enabled without avail");

  property p_rx_consec;
    (rx_st_q == atmop_pkg::ATMOP_RX_RECV && rx_cnt_q != atmop_pkg::ATMOP_CELL_LEN) |-> !rxen_n_q;
  endproperty
  a_rx_consec: assert property (p_rx_consec) else $error("receive enable gap inside cell");

  property p_release;
    disable iff (rst_i) !port_en_i |-> (pa_oe_o == gpio_oe_i) && (pa_o == gpio_out_i);
  endproperty
  a_release: assert property (p_release) else $error("disabled port still drives lines");

  property p_status_undriven;
    disable iff (rst_i) port_en_i |-> !pa_oe_o.rca && !pa_oe_o.rsoc && (pa_oe_o.rxd == 8'h00);
  endproperty
  a_status_undriven: assert property (p_status_undriven) else $error("status line driven");

endmodule // atmop_port
`default_nettype wire

// *** hdl/atmop_pkg.sv ***
`default_nettype none
package atmop_pkg;

  // ==========================================================================
  // cell framing
  localparam logic [5:0] ATMOP_CELL_LEN  = 6'h35;
  localparam logic [5:0] ATMOP_CNT_ZERO  = 6'h00;
  localparam logic [5:0] ATMOP_CNT_ONE   = 6'h01;

  // ==========================================================================
  // port line bundle, one bit per shared port line
  typedef struct packed {
    logic       rca;
    logic       rsoc;
    logic       rxen;
    logic       tsoc;
    logic       tca;
    logic       txen;
    logic [7:0] rxd;
    logic [7:0] txd;
  } atmop_pins_t;

  // lines the device drives while the cell port is enabled
  localparam atmop_pins_t ATMOP_DEV_OE = '{rca: 1'b0, rsoc: 1'b0, rxen: 1'b1,
                                           tsoc: 1'b1, tca: 1'b0, txen: 1'b1,
                                           rxd: 8'h00, txd: 8'hff};
  localparam atmop_pins_t ATMOP_PINS_ZERO = '0;

  // ==========================================================================
  // user side octet carrier
  typedef struct packed {
    logic       sof;
    logic [7:0] data;
  } atmop_octet_t;

  localparam atmop_octet_t ATMOP_OCTET_ZERO = '0;

  // ==========================================================================
  // states
  typedef enum logic [0:0] {
    ATMOP_TX_IDLE = 1'b0,
    ATMOP_TX_SEND = 1'b1
  } atmop_tx_st_t;

  typedef enum logic [0:0] {
    ATMOP_RX_IDLE = 1'b0,
    ATMOP_RX_RECV = 1'b1
  } atmop_rx_st_t;

endpackage
`default_nettype wire

// *** verification/atmop_framer.sv ***
`timescale 1ns/10ps
`default_nettype none
module atmop_framer (
  // bench control
  input  wire logic                   run_i,
  input  wire logic                   tx_stall_i,
  input  wire logic                   rx_go_i,
  // link clocks and lines
  output logic                        tx_fifo_clock_o,
  output logic                        rx_fifo_clock_o,
  input  wire atmop_pkg::atmop_pins_t line_i,
  output var  atmop_pkg::atmop_pins_t drv_o,
  // octets written by the device
  output logic [52:0][7:0]            tx_data_o,
  output logic [52:0]                 tx_sof_o,
  output var int                      tx_cnt_o
);
  // ==========================================================================
  // clocks stand low while not running; rx offset so the two never align
  logic [7:0] rxd_q;
  logic       rsoc_q;
  logic       rca_q;
  int         rx_idx_q;

  initial begin
    tx_fifo_clock_o = 1'b0;
    rx_fifo_clock_o = 1'b0;
    tx_cnt_o = 0;
    rx_idx_q = 0;
    rxd_q = 8'h00;
    rsoc_q = 1'b0;
    rca_q = 1'b0;
  end

  always #62.5 tx_fifo_clock_o = run_i & ~tx_fifo_clock_o;

  initial begin
    #21.7;
    forever #62.5 rx_fifo_clock_o = run_i & ~rx_fifo_clock_o;
  end

  // ==========================================================================
  // transmit fifo; a start flag refills from 0, so a stray start shows as a short count
  always @(posedge tx_fifo_clock_o) begin
    if (!line_i.txen) begin
      tx_data_o[line_i.tsoc ? 0 : tx_cnt_o] <= line_i.txd;
      tx_sof_o[line_i.tsoc ? 0 : tx_cnt_o] <= line_i.tsoc;
      tx_cnt_o <= line_i.tsoc ? 1 : tx_cnt_o + 1;
    end
  end

  always_comb begin
    drv_o = atmop_pkg::ATMOP_PINS_ZERO;
    drv_o.tca = ~tx_stall_i & (tx_cnt_o == 0 || tx_cnt_o == 53);
    drv_o.rca = rca_q;
    drv_o.rsoc = rsoc_q;
    drv_o.rxd = rxd_q;
  end

  // ==========================================================================
  // receive fifo; the bus keeps moving while not enabled, never a stale octet
  always @(posedge rx_fifo_clock_o) begin
    if (!line_i.rxen && rx_idx_q < 53) begin
      rxd_q <= 8'ha0 + 8'(rx_idx_q);
      rsoc_q <= (rx_idx_q == 0);
      rx_idx_q <= rx_idx_q + 1;
    end else begin
      rxd_q <= ~rxd_q;
      rsoc_q <= 1'b0;
      rx_idx_q <= rx_go_i ? rx_idx_q : 0;
    end
    rca_q <= rx_go_i && (rx_idx_q + int'(!line_i.rxen)) < 53;
  end
endmodule // atmop_framer
`default_nettype wire

// *** verification/atmop_port_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module atmop_port_bench;
  // ==========================================================================
  // stimulus and lines
  localparam atmop_pkg::atmop_pins_t FR_OE = '{rca: 1'b1, rsoc: 1'b1, tca: 1'b1,
                                                rxd: 8'hff, default: '0};
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic port_en_i = 1'b1;
  logic run = 1'b1;
  logic tx_stall = 1'b1;
  logic rx_go = 1'b0;
  logic tx_valid_i = 1'b0;
  atmop_pkg::atmop_octet_t tx_octet_i = '0;
  atmop_pkg::atmop_pins_t  gpio_out_i = '0;
  atmop_pkg::atmop_pins_t  gpio_oe_i = '0;
  atmop_pkg::atmop_pins_t  pa_i, pa_o, pa_oe_o, gpio_in_o, fr_drv, fr_oe;
  atmop_pkg::atmop_octet_t rx_octet_o;
  logic tx_fifo_clock, rx_fifo_clock, tx_ready_o, rx_valid_o;
  logic [52:0][7:0] tx_data;
  logic [52:0] tx_sof;
  int tx_cnt, bad_count = 0, total_checks = 0, cycles = 0;

  always #2 core_clk_i = ~core_clk_i;
  // a line nobody drives shows the inverse of the device's current output value
  assign fr_oe = run ? FR_OE : atmop_pkg::ATMOP_PINS_ZERO;
  assign pa_i = (pa_o & pa_oe_o) | (fr_drv & fr_oe & ~pa_oe_o) | (~pa_o & ~pa_oe_o & ~fr_oe);

  atmop_port atmop_port_i (.core_clk_i, .rst_i, .port_en_i, .tx_fifo_clock_i(tx_fifo_clock),
    .rx_fifo_clock_i(rx_fifo_clock), .pa_i, .pa_o, .pa_oe_o, .gpio_out_i, .gpio_oe_i,
    .gpio_in_o, .tx_valid_i, .tx_octet_i, .tx_ready_o, .rx_valid_o, .rx_octet_o);
  atmop_framer atmop_framer_i (.run_i(run), .tx_stall_i(tx_stall), .rx_go_i(rx_go),
    .tx_fifo_clock_o(tx_fifo_clock), .rx_fifo_clock_o(rx_fifo_clock), .line_i(pa_i),
    .drv_o(fr_drv), .tx_data_o(tx_data), .tx_sof_o(tx_sof), .tx_cnt_o(tx_cnt));

  // ==========================================================================
  // checking and closing
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // scenarios
  task automatic send(input logic sof, input logic [7:0] data);
    int n;
    tx_valid_i = 1'b1;
    tx_octet_i = {sof, data};
    n = 0;
    // ready is combinational, so it is judged mid-cycle where it has settled
    do begin
      @(negedge core_clk_i);
      n++;
    end while (tx_ready_o !== 1'b1 && n < 400);
    @(posedge core_clk_i);
    #1;
    check(n < 400, 1'b1, "octet not taken");
  endtask

  task automatic t_tx_cell;
    int hits;
    hits = 0;
    tx_valid_i = 1'b1;
    tx_octet_i = {1'b1, 8'h40};
    repeat (250) begin
      @(posedge core_clk_i);
      #1;
      hits += int'(tx_ready_o === 1'b1);
    end
    check(hits, 0, "cell opened while framer full");
    // an octet without a start mark while idle is taken and thrown away
    send(1'b0, 8'h3c);
    check(pa_o.txen, 1'b1, "idle octet sent");
    tx_stall = 1'b0;
    for (int k = 0; k < 53; k++) begin
      send(k == 0, 8'h40 + 8'(k));
      // a gap mid-cell must write nothing
      if (k == 9) begin
        tx_valid_i = 1'b0;
        repeat (200) @(posedge core_clk_i);
        #1;
      end
    end
    tx_valid_i = 1'b0;
    repeat (300) @(posedge core_clk_i);
    check(tx_cnt, 53, "octet count");
    check(tx_sof, 53'h1, "start flags");
    for (int k = 0; k < 53; k++) check(tx_data[k], 8'h40 + 8'(k), "octet value");
  endtask

  task automatic count_rx(output int n);
    n = 0;
    repeat (300) begin
      @(posedge core_clk_i);
      #1;
      n += int'(rx_valid_o === 1'b1);
    end
  endtask

  task automatic t_rx_cell;
    int n;
    count_rx(n);
    check(n, 0, "octet without cell");
    check(pa_o.rxen, 1'b1, "enable without cell");
    rx_go = 1'b1;
    for (int k = 0; k < 53; k++) begin
      n = 0;
      do begin
        @(posedge core_clk_i);
        #1;
        n++;
      end while (rx_valid_o !== 1'b1 && n < 200);
      check(rx_octet_o, {k == 0, 8'ha0 + 8'(k)}, "received octet");
    end
    rx_go = 1'b0;
    count_rx(n);
    check(n, 0, "octet after burst");
  endtask

  task automatic t_gpio;
    atmop_pkg::atmop_pins_t gout, goe, lvl;
    gout = 22'h2c5a93;
    goe = 22'h0f0f3c;
    lvl = (gout & goe) | (~gout & ~goe);
    run = 1'b0;
    port_en_i = 1'b0;
    gpio_out_i = gout;
    gpio_oe_i = goe;
    repeat (3) @(posedge core_clk_i);
    #1;
    check(pa_o, gout, "line values");
    check(pa_oe_o, goe, "line enables");
    check(gpio_in_o, lvl, "line levels");
  endtask

  initial begin
    repeat (2) @(posedge core_clk_i);
    #1;
    check(pa_o.txen, 1'b1, "transmit idle");
    check(pa_o.rxen, 1'b1, "receive idle");
    check(pa_o.tsoc, 1'b0, "start idle");
    check(pa_oe_o, atmop_pkg::ATMOP_DEV_OE, "enabled drive");
    rst_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1;
    t_tx_cell();
    t_rx_cell();
    t_gpio();
    finish_test();
  end
endmodule // atmop_port_bench
`default_nettype wire
